/* File: node_filter_pkg.sv */
// shared constants and types for the asynchronous request node filter
package node_filter_pkg;

    // ****************************************************************
    // register map, byte addresses
    // ****************************************************************
    localparam logic [11:0] upper_set_addr = 12'h100;
    localparam logic [11:0] upper_clear_addr = 12'h104;
    localparam logic [11:0] lower_set_addr = 12'h108;
    localparam logic [11:0] lower_clear_addr = 12'h10C;
    localparam logic [31:0] filter_reset = 32'h00000000;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int remote_bus_accept_all = 31;
    localparam int upper_node_base = 32;
    localparam logic [5:0] broadcast_node = 6'h3F;

    // ****************************************************************
    // bus answers and request carriers
    // ****************************************************************
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

    typedef enum logic [1:0]
    {
        ctx_other = 2'b00,
        ctx_physical = 2'b01,
        async_request_receive_context = 2'b10
    } target_ctx_type;

    typedef struct packed
    {
        logic local_bus;             // source sits on our own bus
        logic [5:0] node;            // source node number
        target_ctx_type ctx;         // receive context the packet heads for
    } request_type;

    typedef struct packed
    {
        logic accept;                // acknowledge and queue the request
        request_type req;            // the request that was judged
    } decision_type;

endpackage : node_filter_pkg

/* File: async_request_node_filter.sv */
// per-node acceptance filter for received asynchronous requests
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

// What this block does
// [RULE1] one enable bit per source node decides if its requests pass
// [RULE2] lower register bit n governs local node n, n from 0 to 31
// [RULE3] upper register bits 19 to 0 govern local nodes 51 to 32
// [RULE4] a set enable bit for a local node accepts its requests
// [RULE5] lower register behaves like the upper one for its node range; upper bit 31 is the remote bus switch, lower bit 31 is node 31
// [RULE6] lower filter is set at 108h and cleared at 10Ch
// [RULE7] set address sets ones, clear address clears ones, both read back
// [RULE8] requests whose node bit is clear are neither acked nor queued
// [RULE9] remote bus requests refused unless upper bit 31 is set
// [RULE10] check applies to physical and asynchronous request contexts
module async_request_node_filter
(
    input wire logic aclk,                         // 125 MHz clock
    input wire logic aresetn,                      // synchronous reset
    input wire logic [11:0] s_axi_awaddr,          // write address
    input wire logic s_axi_awvalid,                // write address valid
    output logic s_axi_awready,                    // write address ready
    input wire logic [31:0] s_axi_wdata,           // write data
    input wire logic [3:0] s_axi_wstrb,            // byte enables
    input wire logic s_axi_wvalid,                 // write data valid
    output logic s_axi_wready,                     // write data ready
    output logic [1:0] s_axi_bresp,                // write response
    output logic s_axi_bvalid,                     // write response valid
    input wire logic s_axi_bready,                 // response taken
    input wire logic [11:0] s_axi_araddr,          // read address
    input wire logic s_axi_arvalid,                // read address valid
    output logic s_axi_arready,                    // read address ready
    output logic [31:0] s_axi_rdata,               // read data
    output logic [1:0] s_axi_rresp,                // read response
    output logic s_axi_rvalid,                     // read data valid
    input wire logic s_axi_rready,                 // read data taken
    input wire logic req_valid,                    // request header present
    input wire node_filter_pkg::request_type req,  // request to judge
    output logic dec_valid,                        // decision pulse
    output node_filter_pkg::decision_type dec      // registered verdict
);

    // ****************************************************************
    // state
    // ****************************************************************
    logic [31:0] lower_r, lower_nxt, upper_r, upper_nxt;
    logic aw_held_r, w_held_r, bvalid_r, rvalid_r, dec_valid_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r, rdata_r;
    logic [3:0] wstrb_r;
    logic [1:0] bresp_r, rresp_r;
    node_filter_pkg::decision_type dec_r, dec_nxt;

    // ****************************************************************
    // write path: address and data caught in either order
    // ****************************************************************
    wire aw_take = s_axi_awvalid & ~aw_held_r;
    wire w_take = s_axi_wvalid & ~w_held_r;
    wire do_write = aw_held_r & w_held_r & ~bvalid_r;
    wire hit_lo_set = awaddr_r == node_filter_pkg::lower_set_addr;
    wire hit_lo_clr = awaddr_r == node_filter_pkg::lower_clear_addr;
    wire hit_hi_set = awaddr_r == node_filter_pkg::upper_set_addr;
    wire hit_hi_clr = awaddr_r == node_filter_pkg::upper_clear_addr;
    wire wr_mapped = hit_lo_set | hit_lo_clr | hit_hi_set | hit_hi_clr;
    logic [31:0] strb_mask;

    // byte enables widen into a bit mask so partial writes touch only
    // the lanes they name
    genvar b;
    generate
        for (b = 0; b < 4; b++)
        begin : g_lane
            assign strb_mask[8*b +: 8] = {8{wstrb_r[b]}};
        end
    endgenerate

    wire [31:0] wr_bits = wdata_r & strb_mask;

    // separate set and clear addresses avoid read-modify-write races with
    // the receive path; zero bits leave the filter alone
    assign lower_nxt = !do_write ? lower_r :
                       hit_lo_set ? (lower_r | wr_bits) :          // RULE6
                       hit_lo_clr ? (lower_r & ~wr_bits) : lower_r; // RULE7
    assign upper_nxt = !do_write ? upper_r :
                       hit_hi_set ? (upper_r | wr_bits) :          // RULE7
                       hit_hi_clr ? (upper_r & ~wr_bits) : upper_r; // RULE5

    assign s_axi_awready = ~aw_held_r;
    assign s_axi_wready = ~w_held_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // filter registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            lower_r <= node_filter_pkg::filter_reset;
            upper_r <= node_filter_pkg::filter_reset;
        end
        else
        begin
            lower_r <= lower_nxt;
            upper_r <= upper_nxt;
        end
    end

    // write channel holding and response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= node_filter_pkg::resp_okay;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end
        else
        begin
            if (aw_take)
            begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (w_take)
            begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_mapped ? node_filter_pkg::resp_okay
                                     : node_filter_pkg::resp_slverr;
            end
            else if (bvalid_r && s_axi_bready)
                bvalid_r <= 1'b0;
        end
    end

    // ****************************************************************
    // read path: both addresses of a pair read the current filter
    // ****************************************************************
    wire ar_take = s_axi_arvalid & ~rvalid_r;
    wire rd_lo = (s_axi_araddr == node_filter_pkg::lower_set_addr) |
                 (s_axi_araddr == node_filter_pkg::lower_clear_addr);
    wire rd_hi = (s_axi_araddr == node_filter_pkg::upper_set_addr) |
                 (s_axi_araddr == node_filter_pkg::upper_clear_addr);
    wire [31:0] rd_value = rd_lo ? lower_r :                        // RULE7
                           rd_hi ? upper_r : 32'h00000000;

    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // read data register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= node_filter_pkg::resp_okay;
        end
        else if (ar_take)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_value;
            rresp_r <= (rd_lo | rd_hi) ? node_filter_pkg::resp_okay
                                       : node_filter_pkg::resp_slverr;
        end
        else if (s_axi_rready)
            rvalid_r <= 1'b0;
    end

    // ****************************************************************
    // request judgement
    // ****************************************************************
    // nodes 0..31 from the lower word, 32..62 from upper bits 0..30;
    // broadcast node 63 has no enable bit; a tied-off zero keeps the
    // index in range so it is refused on the local bus in the physical and asynchronous request contexts
    wire [63:0] node_enable = {1'b0, upper_r[30:0], lower_r};    // RULE2 RULE3
    wire node_known = req.node != node_filter_pkg::broadcast_node;
    wire node_bit = node_known & node_enable[req.node];           // RULE1
    wire checked_ctx = (req.ctx == node_filter_pkg::ctx_physical) |
        (req.ctx == node_filter_pkg::async_request_receive_context); // RULE10
    wire source_ok = req.local_bus ? node_bit                     // RULE4
                   : upper_r[node_filter_pkg::remote_bus_accept_all]; // RULE9

    // a refused request gets accept low, so the link neither acks nor queues
    assign dec_nxt = '{accept: ~checked_ctx | source_ok, req: req}; // RULE8

    // verdict register, one cycle after the request
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dec_valid_r <= 1'b0;
            dec_r <= '0;
        end
        else
        begin
            dec_valid_r <= req_valid;
            dec_r <= dec_nxt;
        end
    end

    assign dec_valid = dec_valid_r;
    assign dec = dec_r;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_lower_set_or: assert property ( // RULE6
        do_write && hit_lo_set |=> lower_r == ($past(lower_r) | $past(wr_bits)))
        else $error("lower set write did not or in the ones");
    a_lower_clear_and: assert property ( // RULE7
        do_write && hit_lo_clr |=> lower_r == ($past(lower_r) & ~$past(wr_bits)))
        else $error("lower clear write did not clear the ones");
    a_upper_clear_and: assert property ( // RULE5
        do_write && hit_hi_clr |=> upper_r == ($past(upper_r) & ~$past(wr_bits)))
        else $error("upper clear write did not clear the ones");
    a_filter_steady: assert property ( // RULE1
        !do_write |=> $stable(lower_r) && $stable(upper_r))
        else $error("filter changed without a write");
    a_low_node_gate: assert property ( // RULE2
        req_valid && req.local_bus && req.node < 6'd32 && checked_ctx
        |=> dec_valid && dec.accept == $past(lower_r[req.node[4:0]]))
        else $error("lower node verdict wrong");
    a_high_node_gate: assert property ( // RULE3
        req_valid && req.local_bus && req.node >= 6'd32 && req.node < 6'd52
        && checked_ctx
        |=> dec.accept == $past(upper_r[req.node[4:0]]))
        else $error("upper node verdict wrong");
    a_remote_refuse: assert property ( // RULE9
        req_valid && !req.local_bus && checked_ctx
        |=> dec.accept == $past(upper_r[31]))
        else $error("remote bus verdict wrong");
    a_other_ctx_pass: assert property ( // RULE10
        req_valid && !checked_ctx |=> dec_valid && dec.accept)
        else $error("unchecked context was refused");
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_read_back: assert property ( // RULE7
        ar_take && rd_lo |=> s_axi_rvalid && s_axi_rdata == $past(lower_r))
        else $error("lower read back wrong");
    a_broadcast_refuse: assert property ( // RULE8
        req_valid && req.local_bus && checked_ctx
        && req.node == node_filter_pkg::broadcast_node
        |=> !dec.accept)
        else $error("broadcast node was accepted");
    a_verdict_quiet: assert property ( // RULE8
        !req_valid |=> !dec_valid)
        else $error("verdict pulse without a request");

endmodule : async_request_node_filter

/* File: request_source.sv */
// request source model standing in for the link receive path
`timescale 1ns/100ps
module request_source
(
    input wire logic aclk,                         // 125 MHz clock
    output logic req_valid,                        // one-cycle header pulse
    output node_filter_pkg::request_type req       // header fields
);
    // ****************************************************************
    // header issue
    // ****************************************************************
    initial
    begin
        req_valid = 1'h0;
        req = 9'h000;
    end

    // called just after an edge; a released header shows the inverse so
    // stale fields can never pass for a fresh request
    task automatic send(input node_filter_pkg::request_type r);
        begin
            req_valid <= 1'h1;
            req <= r;
            @(posedge aclk);
            req_valid <= 1'h0;
            req <= node_filter_pkg::request_type'(~r);
        end
    endtask : send
endmodule : request_source

/* File: async_request_node_filter_bench.sv */
// self-checking bench for the asynchronous request node filter
`timescale 1ns/100ps
module async_request_node_filter_bench;
    localparam logic [11:0] lo_set = node_filter_pkg::lower_set_addr;
    localparam logic [11:0] lo_clr = node_filter_pkg::lower_clear_addr;
    localparam logic [11:0] up_set = node_filter_pkg::upper_set_addr;
    localparam logic [11:0] up_clr = node_filter_pkg::upper_clear_addr;
    localparam logic [1:0] okay = node_filter_pkg::resp_okay;
    localparam logic [1:0] slverr = node_filter_pkg::resp_slverr;
    localparam node_filter_pkg::target_ctx_type asy =
        node_filter_pkg::async_request_receive_context;
    localparam node_filter_pkg::target_ctx_type phy =
        node_filter_pkg::ctx_physical;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, req_valid, dec_valid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    node_filter_pkg::request_type req;
    node_filter_pkg::decision_type dec;
    int errors = 0;
    int total_checks = 0;

    // 8 ns period
    always #4 aclk = ~aclk;

    async_request_node_filter u_dut
    (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .req_valid(req_valid), .req(req),
        .dec_valid(dec_valid), .dec(dec)
    );

    request_source u_src
    (
        .aclk(aclk), .req_valid(req_valid), .req(req)
    );

    // ****************************************************************
    // reporting
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string m);
        begin
            total_checks++;
            if (got !== exp)
            begin
                errors++;
                $display("unexpected at %0t: %s", $time, m);
            end
        end
    endtask : chk

    task automatic finish_test;
        begin
            $display("checks %0d errors %0d", total_checks, errors);
            if (errors == 0 && total_checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask : finish_test

    // a wait that runs out of cycles ends the run at once
    task automatic hang_check(input int n);
        begin
            if (n >= 40)
            begin
                errors++;
                $display("unexpected at %0t: bus wait expired", $time);
                finish_test();
            end
        end
    endtask : hang_check

    // ****************************************************************
    // bus cycles
    // ****************************************************************
    // address and data offered together, each dropped once it is taken;
    // bready only follows bvalid so the slave must hold its response
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic [1:0] er);
        int n;
        begin
            n = 0;
            @(posedge aclk);
            awaddr <= a;
            wdata <= d;
            wstrb <= s;
            awvalid <= 1'h1;
            wvalid <= 1'h1;
            while (n < 40 && !(bvalid && bready))
            begin
                @(posedge aclk);
                n++;
                if (awready)
                    awvalid <= 1'h0;
                if (wready)
                    wvalid <= 1'h0;
                if (bvalid)
                    bready <= 1'h1;
            end
            hang_check(n);
            bready <= 1'h0;
            chk({30'h0, bresp}, {30'h0, er}, "write response");
        end
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a, input logic [31:0] ed,
        input logic [1:0] er);
        int n;
        begin
            n = 0;
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1'h1;
            rready <= 1'h1;
            while (n < 40 && !(rvalid && rready))
            begin
                @(posedge aclk);
                n++;
                if (arready)
                    arvalid <= 1'h0;
            end
            hang_check(n);
            rready <= 1'h0;
            chk(rdata, ed, "read data");
            chk({30'h0, rresp}, {30'h0, er}, "read response");
        end
    endtask : axi_read

    // one request header, verdict looked at in the cycle it stands
    task automatic judge(input logic lb, input logic [5:0] nd,
        input node_filter_pkg::target_ctx_type c, input logic ex);
        node_filter_pkg::request_type r;
        begin
            r.local_bus = lb;
            r.node = nd;
            r.ctx = c;
            @(posedge aclk);
            u_src.send(r);
            #1;
            chk({30'h0, dec_valid, dec.accept}, {30'h0, 1'h1, ex}, "verdict");
            chk({23'h0, dec.req}, {23'h0, r}, "judged header");
            // the verdict is a one-cycle pulse and must drop again
            @(posedge aclk);
            #1;
            chk({31'h0, dec_valid}, 32'h00000000, "verdict pulse");
        end
    endtask : judge

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        for (int i = 0; i < 4; i++)
            axi_read(12'h100 + 12'(4 * i), 32'h00000000, okay);
        judge(1'h1, 6'h00, asy, 1'h0);
        axi_write(lo_set, 32'h80000001, 4'hF, okay);
        axi_read(lo_set, 32'h80000001, okay);
        axi_read(lo_clr, 32'h80000001, okay);
        judge(1'h1, 6'h00, asy, 1'h1);
        judge(1'h1, 6'h1F, phy, 1'h1);
        judge(1'h1, 6'h01, asy, 1'h0);
        judge(1'h1, 6'h01, phy, 1'h0);
        judge(1'h1, 6'h01, node_filter_pkg::ctx_other, 1'h1);
        judge(1'h1, 6'h20, asy, 1'h0);
        axi_write(lo_clr, 32'h00000001, 4'hF, okay);
        axi_read(lo_set, 32'h80000000, okay);
        judge(1'h1, 6'h00, asy, 1'h0);
        axi_write(lo_set, 32'hFFFFFFFF, 4'h2, okay);
        axi_read(lo_clr, 32'h8000FF00, okay);
        axi_write(up_set, 32'h00080001, 4'hF, okay);
        judge(1'h1, 6'h20, asy, 1'h1);
        judge(1'h1, 6'h33, phy, 1'h1);
        judge(1'h1, 6'h32, asy, 1'h0);
        judge(1'h1, 6'h21, asy, 1'h0);
        judge(1'h0, 6'h00, asy, 1'h0);
        axi_write(up_set, 32'h80000000, 4'hF, okay);
        judge(1'h0, 6'h02, asy, 1'h1);
        judge(1'h0, 6'h02, phy, 1'h1);
        axi_write(12'h0F0, 32'hFFFFFFFF, 4'hF, slverr);
        axi_read(12'h0F0, 32'h00000000, slverr);
        axi_read(lo_set, 32'h8000FF00, okay);
        axi_write(up_clr, 32'h00000001, 4'hF, okay);
        axi_read(up_set, 32'h80080000, okay);
        judge(1'h1, 6'h20, asy, 1'h0);
        judge(1'h1, 6'h33, asy, 1'h1);
        axi_write(up_set, 32'h7FF00000, 4'hF, okay);
        judge(1'h1, 6'h3E, asy, 1'h1);
        judge(1'h1, 6'h3F, phy, 1'h0);
        axi_read(up_clr, 32'hFFF80000, okay);
        // a mid-run reset must bring both filters back to zero
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        axi_read(lo_set, 32'h00000000, okay);
        axi_read(up_set, 32'h00000000, okay);
        judge(1'h1, 6'h33, asy, 1'h0);
        finish_test();
    end
endmodule : async_request_node_filter_bench
